/* rtl/fpm_pkg.sv */
// Constants shared by the programmer-mode flash front end.
// Assumes a single 100 MHz clock and an asynchronous power-on reset.
//
// Functional notes
// - Auto-program writes one 128-byte block.
// - Bad address still writes, but flags error.
// - Address taken only in second cycle.
// - Polling bits held until next command write.
// - Auto-erase always erases whole array.
// - Status code persists until different command.
// - Status byte layout, all bits reset zero.
// - Bit seven shows running or finished.
// - Bit six shows normal or abnormal end.
// - Polling byte values per state.
// - Program is command plus 128 writes.
// - Finished operations return to command wait.
`default_nettype none
package fpm_pkg;
  localparam logic [7:0] CMD_READ    = 8'h00;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE   = 8'h20;
  localparam logic [7:0] CMD_STATUS  = 8'h71;
  localparam int BLOCK_BYTES   = 128;
  localparam int BLOCK_LSB     = 7;
  localparam int ADDR_W        = 18;
  localparam int DATA_W        = 8;
  localparam int ST_ABNORMAL   = 7;
  localparam int ST_CMD_ERR    = 6;
  localparam int ST_PROG_ERR   = 5;
  localparam int ST_ERASE_ERR  = 4;
  localparam int ST_COUNT_ERR  = 1;
  localparam int ST_ADDR_ERR   = 0;
  localparam int POLL_DONE     = 7;
  localparam int POLL_OK       = 6;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  typedef enum logic [1:0] {SEL_MEM, SEL_POLL, SEL_STATUS} fpm_sel_t;
  typedef enum {
    FS_READ, FS_WAIT, FS_PROG_ADDR, FS_PROG_DATA, FS_PROG_RUN,
    FS_ERASE2, FS_ERASE_RUN, FS_STAT2
  } fpm_state_t;
endpackage
`default_nettype wire

/* rtl/fpm_buf2.sv */
// Two-entry buffer between the pin capture logic and the array write port.
// Assumes both sides sit on the same clock.
`default_nettype none
module fpm_buf2 import fpm_pkg::*; #(
  parameter int WIDTH = 26
) (
  // Clock and reset.
  input  wire logic             ref_clk,
  input  wire logic             sys_rst,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  initial begin
    if (WIDTH < 1) $error("fpm_buf2 width must be positive");
  end

  logic [WIDTH-1:0] mem_reg [2];
  logic [WIDTH-1:0] mem_next [2];
  logic             wp_reg, wp_next, rp_reg, rp_next;
  logic [1:0]       cnt_reg, cnt_next;
  logic             push, pop;

  assign in_ready  = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data  = mem_reg[rp_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    mem_next = mem_reg;
    wp_next  = wp_reg;
    rp_next  = rp_reg;
    cnt_next = cnt_reg;
    if (push) begin
      mem_next[wp_reg] = in_data;
      wp_next = ~wp_reg;
    end
    if (pop) begin
      rp_next = ~rp_reg;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 2'h1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      wp_reg     <= 1'b0;
      rp_reg     <= 1'b0;
      cnt_reg    <= 2'h0;
    end else begin
      mem_reg <= mem_next;
      wp_reg  <= wp_next;
      rp_reg  <= rp_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

/* rtl/fpm_auto_ops.sv */
// Programmer-mode command front end: auto-program, auto-erase, status read, polling.
// Assumes the flash array core performs the timed program and erase itself and reports back.
`default_nettype none
module fpm_auto_ops import fpm_pkg::*; #(
  parameter int ADDR_LIMIT = 1 << ADDR_W
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Programmer pins.
  input  wire logic              ce_n,
  input  wire logic              oe_n,
  input  wire logic              we_n,
  input  wire logic              flash_write_permit,
  input  wire logic [ADDR_W-1:0] address_bus,
  input  wire logic [DATA_W-1:0] data_bus_in,
  output logic [DATA_W-1:0]      data_bus_out,
  output logic                   data_bus_oe_n,
  // Array read port.
  output logic [ADDR_W-1:0]      mem_rd_addr,
  input  wire logic [DATA_W-1:0] mem_rd_data,
  // Array program byte stream.
  output logic                   prog_valid,
  input  wire logic              prog_ready,
  output logic [ADDR_W-1:0]      prog_addr,
  output logic [DATA_W-1:0]      prog_data,
  // Array operation control and result.
  output logic                   prog_commit,
  output logic                   erase_start,
  input  wire logic              op_done,
  input  wire logic              op_fail,
  input  wire logic              op_count_exceeded,
  // Status.
  output logic                   busy
);
  initial begin
    if (ADDR_LIMIT < 1 || ADDR_LIMIT > (1 << ADDR_W)) $error("fpm_auto_ops address limit out of range");
  end

  localparam int PW = 4 + ADDR_W + DATA_W;

  // Pin inputs pass three flip-flops; a bit moves once stages two and three agree.
  logic [PW-1:0] s1_reg, s2_reg, s3_reg, f_reg, f_next;
  always_comb begin
    for (int i = 0; i < PW; i++) begin
      f_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : f_reg[i];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_reg <= {3'b111, {(PW-3){1'b0}}};
      s2_reg <= {3'b111, {(PW-3){1'b0}}};
      s3_reg <= {3'b111, {(PW-3){1'b0}}};
      f_reg  <= {3'b111, {(PW-3){1'b0}}};
    end else begin
      s1_reg <= {ce_n, oe_n, we_n, flash_write_permit, address_bus, data_bus_in};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      f_reg  <= f_next;
    end
  end

  logic              ce_f, oe_f, we_f, fwe_f, we_d_reg;
  logic [ADDR_W-1:0] a_f;
  logic [DATA_W-1:0] d_f;
  logic              wr_ev;
  assign {ce_f, oe_f, we_f, fwe_f, a_f, d_f} = f_reg;
  // The write is taken on the trailing edge of the strobe, when data has settled.
  assign wr_ev = we_f && !we_d_reg && !ce_f;

  // Buffer between captured bytes and the array port.
  logic                     bin_valid, bin_ready;
  logic [ADDR_W+DATA_W-1:0] bout;

  fpm_state_t        st_reg, st_next;
  fpm_sel_t          sel_reg, sel_next;
  logic [7:0]        stat_reg, stat_next;
  logic              done_reg, done_next, ok_reg, ok_next;
  logic              aerr_reg, aerr_next;
  logic [ADDR_W-1:0] blk_reg, blk_next, ba_reg, ba_next;
  logic [DATA_W-1:0] bd_reg, bd_next;
  logic [7:0]        cnt_reg, cnt_next;
  logic              pend_reg, pend_next, commit_reg, commit_next, erase_reg, erase_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic              oe_reg, oe_next;

  fpm_buf2 #(.WIDTH(ADDR_W + DATA_W)) u_buf (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .in_valid (bin_valid),
    .in_ready (bin_ready),
    .in_data  ({ba_reg, bd_reg}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data (bout)
  );
  assign {prog_addr, prog_data} = bout;

  assign bin_valid     = pend_reg;
  assign prog_commit   = commit_reg;
  assign erase_start   = erase_reg;
  assign data_bus_out  = dout_reg;
  assign data_bus_oe_n = oe_reg;
  assign mem_rd_addr   = a_f;
  assign busy          = (st_reg == FS_PROG_RUN) || (st_reg == FS_ERASE_RUN) || (st_reg == FS_PROG_DATA);

  always_comb begin
    st_next     = st_reg;
    sel_next    = sel_reg;
    stat_next   = stat_reg;
    done_next   = done_reg;
    ok_next     = ok_reg;
    aerr_next   = aerr_reg;
    blk_next    = blk_reg;
    ba_next     = ba_reg;
    bd_next     = bd_reg;
    cnt_next    = cnt_reg;
    pend_next   = pend_reg && !bin_ready;
    commit_next = 1'b0;
    erase_next  = 1'b0;
    // Writes in the running states are ignored; the programmer must not issue them.
    if (wr_ev && (st_reg == FS_READ || st_reg == FS_WAIT)) begin
      // A new command drops the held polling bits.
      done_next = 1'b0;
      ok_next   = 1'b0;
      // Only a status command keeps the return code.
      if (d_f != CMD_STATUS) begin
        stat_next = STATUS_RESET;
      end
      sel_next = SEL_POLL;
      if (d_f == CMD_READ) begin
        st_next  = FS_READ;
        sel_next = SEL_MEM;
      end else if ((d_f == CMD_PROGRAM || d_f == CMD_ERASE) && !fwe_f) begin
        // Program and erase without write permit end abnormally.
        stat_next[ST_CMD_ERR]  = 1'b1;
        stat_next[ST_ABNORMAL] = 1'b1;
        done_next = 1'b1;
        st_next   = FS_WAIT;
      end else if (d_f == CMD_PROGRAM) begin
        st_next = FS_PROG_ADDR;
      end else if (d_f == CMD_ERASE) begin
        st_next = FS_ERASE2;
      end else if (d_f == CMD_STATUS) begin
        st_next = FS_STAT2;
      end else begin
        stat_next[ST_CMD_ERR]  = 1'b1;
        stat_next[ST_ABNORMAL] = 1'b1;
        done_next = 1'b1;
        st_next   = FS_WAIT;
      end
    end else if (wr_ev && st_reg == FS_PROG_ADDR) begin
      // The block address is latched here and never again.
      blk_next  = {a_f[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
      // A misaligned or out-of-range address still writes but is flagged.
      aerr_next = (a_f[BLOCK_LSB-1:0] != '0) || (int'(a_f) >= ADDR_LIMIT);
      ba_next   = {a_f[ADDR_W-1:BLOCK_LSB], {BLOCK_LSB{1'b0}}};
      bd_next   = d_f;
      pend_next = 1'b1;
      cnt_next  = 8'h01;
      st_next   = FS_PROG_DATA;
    end else if (wr_ev && st_reg == FS_PROG_DATA && !pend_reg) begin
      // Later writes carry data only; addresses follow the block count.
      ba_next   = blk_reg | ADDR_W'(cnt_reg[BLOCK_LSB-1:0]);
      bd_next   = d_f;
      pend_next = 1'b1;
      cnt_next  = cnt_reg + 8'h01;
    end else if (st_reg == FS_PROG_DATA && cnt_reg == 8'(BLOCK_BYTES) && !pend_reg && !prog_valid) begin
      // The block is committed once every byte has left the buffer.
      commit_next = 1'b1;
      st_next     = FS_PROG_RUN;
    end else if (wr_ev && st_reg == FS_ERASE2) begin
      if (d_f == CMD_ERASE) begin
        // Erase has no address: the whole array goes.
        erase_next = 1'b1;
        st_next    = FS_ERASE_RUN;
      end else begin
        stat_next[ST_CMD_ERR]  = 1'b1;
        stat_next[ST_ABNORMAL] = 1'b1;
        done_next = 1'b1;
        st_next   = FS_WAIT;
      end
    end else if (wr_ev && st_reg == FS_STAT2) begin
      if (d_f != CMD_STATUS) begin
        stat_next[ST_CMD_ERR]  = 1'b1;
        stat_next[ST_ABNORMAL] = 1'b1;
      end
      sel_next = SEL_STATUS;
      st_next  = FS_WAIT;
    end else if (op_done && (st_reg == FS_PROG_RUN || st_reg == FS_ERASE_RUN)) begin
      done_next = 1'b1;
      ok_next   = !op_fail && !(st_reg == FS_PROG_RUN && aerr_reg);
      if (op_fail && st_reg == FS_PROG_RUN) begin
        stat_next[ST_PROG_ERR] = 1'b1;
      end
      if (op_fail && st_reg == FS_ERASE_RUN) begin
        stat_next[ST_ERASE_ERR] = 1'b1;
      end
      // Status bits only ever set here, which leaves the code for a later status read.
      stat_next[ST_COUNT_ERR] = stat_reg[ST_COUNT_ERR] | op_count_exceeded;
      stat_next[ST_ADDR_ERR]  = stat_reg[ST_ADDR_ERR] | (st_reg == FS_PROG_RUN && aerr_reg);
      stat_next[ST_ABNORMAL]  = stat_reg[ST_ABNORMAL] | op_fail | (st_reg == FS_PROG_RUN && aerr_reg);
      st_next = FS_WAIT;
    end
    // Output byte is registered so the pins never see a decode glitch.
    oe_next = !(!ce_f && !oe_f);
    unique case (sel_reg)
      SEL_MEM:    dout_next = mem_rd_data;
      SEL_POLL:   dout_next = {done_reg, ok_reg, 6'h00};
      SEL_STATUS: dout_next = {stat_reg[7:4], 2'b00, stat_reg[1:0]};
      default:    dout_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      we_d_reg   <= 1'b1;
      st_reg     <= FS_READ;
      sel_reg    <= SEL_MEM;
      stat_reg   <= STATUS_RESET;
      done_reg   <= 1'b0;
      ok_reg     <= 1'b0;
      aerr_reg   <= 1'b0;
      blk_reg    <= '0;
      ba_reg     <= '0;
      bd_reg     <= '0;
      cnt_reg    <= 8'h00;
      pend_reg   <= 1'b0;
      commit_reg <= 1'b0;
      erase_reg  <= 1'b0;
      dout_reg   <= 8'h00;
      oe_reg     <= 1'b1;
    end else begin
      we_d_reg   <= we_f;
      st_reg     <= st_next;
      sel_reg    <= sel_next;
      stat_reg   <= stat_next;
      done_reg   <= done_next;
      ok_reg     <= ok_next;
      aerr_reg   <= aerr_next;
      blk_reg    <= blk_next;
      ba_reg     <= ba_next;
      bd_reg     <= bd_next;
      cnt_reg    <= cnt_next;
      pend_reg   <= pend_next;
      commit_reg <= commit_next;
      erase_reg  <= erase_next;
      dout_reg   <= dout_next;
      oe_reg     <= oe_next;
    end
  end
endmodule
`default_nettype wire

/* test/fpm_auto_ops_asserts.sv */
// Port-level checks on the programmer-mode front end.
// Assumes it is bound to fpm_auto_ops and sees only that module's ports.
`default_nettype none
module fpm_auto_ops_asserts import fpm_pkg::*; (
  // Clock, reset and programmer pins.
  input wire logic              ref_clk,
  input wire logic              sys_rst,
  input wire logic              ce_n,
  input wire logic              oe_n,
  input wire logic [DATA_W-1:0] data_bus_out,
  input wire logic              data_bus_oe_n,
  // Array side.
  input wire logic              prog_valid,
  input wire logic              prog_ready,
  input wire logic [ADDR_W-1:0] prog_addr,
  input wire logic [DATA_W-1:0] prog_data,
  input wire logic              prog_commit,
  input wire logic              erase_start,
  input wire logic              op_done,
  input wire logic              busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Eight cycles cover the pin filter plus the output register.
  read_drive_a: assert property ((!ce_n && !oe_n) [*8] |-> !data_bus_oe_n)
    else $error("pins not driven during read");
  read_release_a: assert property (ce_n [*8] |-> data_bus_oe_n)
    else $error("pins driven while deselected");
  commit_pulse_a: assert property (prog_commit |=> !prog_commit)
    else $error("commit longer than one cycle");
  erase_pulse_a: assert property (erase_start |=> !erase_start)
    else $error("erase start longer than one cycle");
  op_busy_a: assert property ((prog_commit || erase_start) |=> busy)
    else $error("not busy after operation start");
  busy_fall_a: assert property ($fell(busy) |-> $past(op_done))
    else $error("busy ended without array completion");
  commit_empty_a: assert property (prog_commit |-> !prog_valid)
    else $error("commit before stream drained");
  stream_hold_a: assert property (prog_valid && !prog_ready |=> prog_valid && $stable(prog_addr)
    && $stable(prog_data)) else $error("stream word changed while stalled");
  poll_run_a: assert property (busy [*3] ##0 !data_bus_oe_n |-> data_bus_out == 8'h00)
    else $error("poll byte not zero while running");
endmodule
bind fpm_auto_ops fpm_auto_ops_asserts i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce_n(ce_n), .oe_n(oe_n),
  .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .prog_valid(prog_valid), .prog_ready(prog_ready),
  .prog_addr(prog_addr), .prog_data(prog_data), .prog_commit(prog_commit), .erase_start(erase_start),
  .op_done(op_done), .busy(busy));
`default_nettype wire

/* test/fpm_array_model.sv */
// Behavioural flash array: stream sink, timed program and erase, read port.
// Assumes one clock; the bench forces an abnormal end through fail_req and count_req.
`default_nettype none
module fpm_array_model import fpm_pkg::*; #(
  parameter int RUN_CYCLES = 300
) (
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Stream and operation control.
  input  wire logic              prog_valid,
  output logic                   prog_ready,
  input  wire logic [ADDR_W-1:0] prog_addr,
  input  wire logic [DATA_W-1:0] prog_data,
  input  wire logic              prog_commit,
  input  wire logic              erase_start,
  output logic                   op_done,
  output logic                   op_fail,
  output logic                   op_count_exceeded,
  // Read port and forced faults.
  input  wire logic [ADDR_W-1:0] mem_rd_addr,
  output logic [DATA_W-1:0]      mem_rd_data,
  input  wire logic              fail_req,
  input  wire logic              count_req
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [2:0]        phase;
  int                run;
  // Ready drops three cycles in eight so the two-entry buffer must hold words.
  assign prog_ready  = phase < 3'h5;
  assign mem_rd_data = mem[mem_rd_addr];
  initial foreach (mem[i]) mem[i] = 8'hFF;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase <= 3'h0;
      run <= 0;
      op_done <= 1'b0;
      op_fail <= 1'b0;
      op_count_exceeded <= 1'b0;
    end else begin
      phase <= phase + 3'h1;
      op_done <= 1'b0;
      if (prog_valid && prog_ready) mem[prog_addr] <= prog_data;
      if (erase_start) foreach (mem[i]) mem[i] <= 8'hFF;
      if (prog_commit || erase_start) begin
        run <= RUN_CYCLES;
      end else if (run == 1) begin
        run <= 0;
        op_done <= 1'b1;
        op_fail <= fail_req;
        op_count_exceeded <= count_req;
      end else if (run > 1) begin
        run <= run - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* test/fpm_auto_ops_test.sv */
// Self-checking bench: plays the external programmer against the front end and a model array.
// Assumes the checker is bound from its own file.
`default_nettype none
module fpm_auto_ops_test import fpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              ce_n = 1'b1;
  logic              oe_n = 1'b1;
  logic              we_n = 1'b1;
  logic              flash_write_permit = 1'b1;
  logic              fail_req = 1'b0;
  logic              count_req = 1'b0;
  logic [ADDR_W-1:0] address_bus = 18'h00000;
  logic [DATA_W-1:0] data_bus_in = 8'h00;
  logic [DATA_W-1:0] data_bus_out, prog_data, mem_rd_data;
  logic [ADDR_W-1:0] mem_rd_addr, prog_addr;
  logic              data_bus_oe_n, prog_valid, prog_ready, prog_commit, erase_start;
  logic              op_done, op_fail, op_count_exceeded, busy;
  int                n_fail = 0;
  int                comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  fpm_auto_ops i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .flash_write_permit(flash_write_permit), .address_bus(address_bus), .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out), .data_bus_oe_n(data_bus_oe_n), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .prog_valid(prog_valid), .prog_ready(prog_ready), .prog_addr(prog_addr),
    .prog_data(prog_data), .prog_commit(prog_commit), .erase_start(erase_start), .op_done(op_done),
    .op_fail(op_fail), .op_count_exceeded(op_count_exceeded), .busy(busy));
  fpm_array_model i_array (.ref_clk(ref_clk), .sys_rst(sys_rst), .prog_valid(prog_valid),
    .prog_ready(prog_ready), .prog_addr(prog_addr), .prog_data(prog_data), .prog_commit(prog_commit),
    .erase_start(erase_start), .op_done(op_done), .op_fail(op_fail), .op_count_exceeded(op_count_exceeded),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .fail_req(fail_req), .count_req(count_req));
  task automatic tally_and_finish;
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Writes sit 41 cycles apart so a stalled array never finds the buffer full.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(negedge ref_clk);
    address_bus = a;
    data_bus_in = d;
    {ce_n, we_n} = 2'b00;
    repeat (8) @(negedge ref_clk);
    we_n = 1'b1;
    repeat (8) @(negedge ref_clk);
    ce_n = 1'b1;
    data_bus_in = ~d;
    repeat (24) @(negedge ref_clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp, input string what);
    @(negedge ref_clk);
    address_bus = a;
    {ce_n, oe_n} = 2'b00;
    repeat (10) @(negedge ref_clk);
    chk("output enable", 8'h00, {7'h0, data_bus_oe_n});
    chk(what, exp, data_bus_out);
    {ce_n, oe_n} = 2'b11;
    repeat (10) @(negedge ref_clk);
  endtask
  task automatic cmd2(input logic [7:0] c);
    wr(18'h00000, c);
    wr(18'h00000, c);
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 2000 && busy !== 1'b0; k++) @(negedge ref_clk);
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  function automatic logic [7:0] byte_of(int k);
    return (k < 100) ? 8'(k) ^ 8'h5A : 8'hFF;
  endfunction
  task automatic t_program(input logic [ADDR_W-1:0] a, input logic [7:0] poll);
    wr(18'h00000, CMD_PROGRAM);
    for (int k = 0; k < BLOCK_BYTES; k++) wr((k == 0) ? a : ~a, byte_of(k));
    wait_idle;
    rd(18'h00000, poll, "poll after program");
    rd(18'h00033, poll, "poll held");
  endtask
  task automatic t_readback(input logic [ADDR_W-1:0] blk);
    wr(18'h00000, CMD_READ);
    for (int k = 0; k < BLOCK_BYTES; k += 9) rd(blk | 18'(k), byte_of(k), "programmed byte");
    rd(blk | 18'h0007F, 8'hFF, "last byte");
  endtask
  task automatic t_erase;
    cmd2(CMD_ERASE);
    rd(18'h0002A, 8'h00, "poll while erasing");
    wait_idle;
    rd(18'h0002A, 8'hC0, "poll after erase");
    wr(18'h00000, CMD_READ);
    rd(18'h00105, 8'hFF, "erased byte");
  endtask
  task automatic t_addr_error;
    t_program(18'h00285, 8'h80);
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'h81, "status after bad address");
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'h81, "status kept");
    t_readback(18'h00280);
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'h00, "status cleared");
  endtask
  task automatic t_op_fail;
    {fail_req, count_req} = 2'b11;
    cmd2(CMD_ERASE);
    wait_idle;
    rd(18'h00000, 8'h80, "poll after failed erase");
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'h92, "erase error status");
    {fail_req, count_req} = 2'b00;
  endtask
  task automatic t_cmd_error;
    wr(18'h00000, 8'h55);
    rd(18'h00000, 8'h80, "poll after bad command");
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'hC0, "command error status");
    flash_write_permit = 1'b0;
    wr(18'h00000, CMD_PROGRAM);
    flash_write_permit = 1'b1;
    chk("busy without permit", 8'h00, {7'h0, busy});
    rd(18'h00000, 8'h80, "poll after refused program");
    cmd2(CMD_STATUS);
    rd(18'h00000, 8'hC0, "permit error status");
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("idle output enable", 8'h01, {7'h0, data_bus_oe_n});
    rd(18'h00000, 8'hFF, "memory byte");
    t_program(18'h00100, 8'hC0);
    t_readback(18'h00100);
    t_erase;
    t_addr_error;
    t_op_fail;
    t_cmd_error;
    tally_and_finish;
  end
  initial begin
    repeat (60000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
